/* File: hw/mpb_pkg.sv */
// package for the parameter extraction and braking block
// assumes a 32-bit apb master on pclk
package mpb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OLCFG = 8'h04;
  localparam logic [7:0] OFS_LIMITS = 8'h08;
  localparam logic [7:0] OFS_NVM_RL = 8'h0c;
  localparam logic [7:0] OFS_NVM_KE = 8'h10;
  localparam logic [7:0] OFS_NVM_CL = 8'h14;
  localparam logic [7:0] OFS_NVM_SL = 8'h18;
  localparam logic [7:0] OFS_BRAKE = 8'h1c;
  localparam logic [7:0] OFS_DELTA = 8'h20;
  localparam logic [7:0] OFS_SPEED = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_EST_RL = 8'h2c;
  localparam logic [7:0] OFS_EST_KE = 8'h30;
  localparam logic [7:0] OFS_SHD_RL = 8'h34;
  localparam logic [7:0] OFS_SHD_CL = 8'h38;
  localparam logic [7:0] OFS_SHD_SL = 8'h3c;
  localparam logic [7:0] OFS_IDREF = 8'h40;
  // control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_KE_EN = 1;
  localparam int CTRL_MECH_EN = 2;
  localparam int CTRL_OL_SEL = 3;
  localparam int CTRL_SHADOW = 4;
  localparam int CTRL_ANTI_SURGE_ENABLE = 5;
  localparam int CTRL_AB_EN = 6;
  localparam int CTRL_TORQUE = 7;
  localparam int CTRL_REVERSE = 8;
  localparam int CTRL_SPINDOWN = 9;
  // fixed step lengths in cycles
  localparam int unsigned STEP_CYCLES = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // percentages applied when extraction settings are not selected
  localparam int unsigned CUR_PCT = 80;
  localparam int unsigned SPD_PCT = 50;
endpackage

/* File: hw/mpb_brake_pi.sv */
// pi controller producing the d-axis current reference while braking
// assumes inputs on pclk; clears itself when run is low
`timescale 1ns/10ps
module mpb_brake_pi #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [W-1:0] limit,
  input wire logic [W-1:0] slew,
  input wire logic [W-1:0] bus_cur,
  input wire logic [7:0] kp,
  input wire logic [7:0] ki,
  // result
  output logic [W-1:0] ramp_q,
  output logic [W-1:0] id_ref_q
);
  initial begin
    if (W < 8 || W > 24) $error("mpb_brake_pi: W out of range");
  end
  logic signed [W+1:0] err;
  logic signed [W+17:0] integ_q;
  logic signed [W+17:0] sum;
  logic [W:0] ramp_next;
  assign err = $signed({2'b00, ramp_q}) - $signed({2'b00, bus_cur});
  assign ramp_next = {1'b0, ramp_q} + {1'b0, slew};
  // widen before the product so the gain multiply cannot wrap
  assign sum = integ_q + (W+18)'(err) * (W+18)'($signed({1'b0, kp}));
  // bus limit ramps from zero toward the limit at the slew rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= '0;
    end else if (!run) begin
      ramp_q <= '0;
    end else if (ramp_next >= {1'b0, limit}) begin
      ramp_q <= limit;
    end else begin
      ramp_q <= ramp_next[W-1:0];
    end
  end
  // pi on the bus-current error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_q <= '0;
    end else if (!run) begin
      integ_q <= '0;
    end else begin
      integ_q <= integ_q + (W+18)'(err) * (W+18)'($signed({1'b0, ki}));
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_ref_q <= '0;
    end else if (!run) begin
      id_ref_q <= '0;
    end else if (sum < 0) begin
      id_ref_q <= '0;
    end else if (sum[W+17:W+4] != '0) begin
      id_ref_q <= '1;
    end else begin
      id_ref_q <= sum[W+3:4];
    end
  end
  a_ramp_starts_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(run) |-> ramp_q == '0)
    else $error("ramp did not start at zero");
  a_ramp_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_q <= limit || $changed(limit))
    else $error("ramp exceeded limit");
endmodule // mpb_brake_pi

/* File: hw/mpb_top.sv */
// extraction sequencer, shadow selection and deceleration choice
// assumes an apb master on pclk; speed, bemf and modulation come from the control core
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module mpb_top #(
  parameter int W = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurements from the control core
  input wire logic [W-1:0] speed_now,
  input wire logic [W-1:0] bus_cur,
  input wire logic [W-1:0] mod_index,
  input wire logic [W-1:0] bemf_meas,
  input wire logic [W-1:0] est_res,
  input wire logic [W-1:0] est_ind,
  input wire logic [W-1:0] est_ke,
  input wire logic [W-1:0] est_inertia,
  input wire logic [W-1:0] est_friction,
  // bridge and loop outputs
  output logic bridge_hiz_q,
  output logic [W-1:0] ol_slew_q,
  output logic [W-1:0] ol_cur_ref_q,
  output logic [W-1:0] ol_spd_ref_q,
  output logic [W-1:0] id_ref_q,
  output logic [W-1:0] decel_rate_q,
  output logic brake_active_q,
  output logic surge_active_q
);
  initial begin
    if (W < 8 || W > 16) $error("mpb_top: W must be 8..16");
  end
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_ALIGN = 6'b000010, ST_OPEN = 6'b000100,
    ST_RAMP = 6'b001000, ST_COAST = 6'b010000, ST_DONE = 6'b100000
  } mpb_state_t;
  mpb_state_t st_q;
  logic [31:0] ctrl_q, olcfg_q, limits_q, nvm_rl_q, nvm_ke_q, nvm_cl_q, nvm_sl_q;
  logic [31:0] brake_q, delta_q, speed_q;
  logic [W-1:0] par_res_q, par_ind_q, par_ke_q, par_j_q, par_f_q;
  logic [4:0] cnt_q;
  logic fault_q, done_q;
  logic acc, wr, rd;
  logic mech_run, ol_needed;
  logic [W-1:0] cur_kp, cur_ki, spd_kp, spd_ki;
  logic [W-1:0] tgt, delta_cmd, gap;
  logic fwd_ok, want_brake, brake_d, pi_ramp_unused;
  logic [W-1:0] pi_ramp, pi_id;

  function automatic logic [W-1:0] pick(input logic [W-1:0] nvm, input logic [W-1:0] est,
                                        input logic force_est);
    pick = (force_est || nvm == '0) ? est : nvm;
  endfunction
  function automatic logic [W-1:0] pct(input logic [W-1:0] v, input int unsigned p);
    logic [W+7:0] prod;
    prod = (W+8)'(v) * (W+8)'(p);
    pct = (W)'(prod / (W+8)'(100));
  endfunction

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // read data is loaded in the setup cycle so it stands with pready
  assign rd = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !pready;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= mpb_pkg::RESET_WORD;
      olcfg_q <= mpb_pkg::RESET_WORD;
      limits_q <= mpb_pkg::RESET_WORD;
      nvm_rl_q <= mpb_pkg::RESET_WORD;
      nvm_ke_q <= mpb_pkg::RESET_WORD;
      nvm_cl_q <= mpb_pkg::RESET_WORD;
      nvm_sl_q <= mpb_pkg::RESET_WORD;
      brake_q <= mpb_pkg::RESET_WORD;
      delta_q <= mpb_pkg::RESET_WORD;
      speed_q <= mpb_pkg::RESET_WORD;
    end else begin
      if (st_q != ST_IDLE) ctrl_q[mpb_pkg::CTRL_START] <= 1'b0;
      if (wr && pready) begin
        case (paddr)
          mpb_pkg::OFS_CTRL: ctrl_q <= pwdata;
          mpb_pkg::OFS_OLCFG: olcfg_q <= pwdata;
          mpb_pkg::OFS_LIMITS: limits_q <= pwdata;
          mpb_pkg::OFS_NVM_RL: nvm_rl_q <= pwdata;
          mpb_pkg::OFS_NVM_KE: nvm_ke_q <= pwdata;
          mpb_pkg::OFS_NVM_CL: nvm_cl_q <= pwdata;
          mpb_pkg::OFS_NVM_SL: nvm_sl_q <= pwdata;
          mpb_pkg::OFS_BRAKE: brake_q <= pwdata;
          mpb_pkg::OFS_DELTA: delta_q <= pwdata;
          mpb_pkg::OFS_SPEED: speed_q <= pwdata;
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !pready && (paddr > mpb_pkg::OFS_IDREF || paddr[1:0] != 2'b00);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd && !pready) begin
      case (paddr)
        mpb_pkg::OFS_CTRL: prdata <= ctrl_q;
        mpb_pkg::OFS_OLCFG: prdata <= olcfg_q;
        mpb_pkg::OFS_LIMITS: prdata <= limits_q;
        mpb_pkg::OFS_NVM_RL: prdata <= nvm_rl_q;
        mpb_pkg::OFS_NVM_KE: prdata <= nvm_ke_q;
        mpb_pkg::OFS_NVM_CL: prdata <= nvm_cl_q;
        mpb_pkg::OFS_NVM_SL: prdata <= nvm_sl_q;
        mpb_pkg::OFS_BRAKE: prdata <= brake_q;
        mpb_pkg::OFS_DELTA: prdata <= delta_q;
        mpb_pkg::OFS_SPEED: prdata <= speed_q;
        mpb_pkg::OFS_STATUS: prdata <= {24'h0, brake_active_q, surge_active_q,
                                        st_q};
        mpb_pkg::OFS_EST_RL: prdata <= {16'(par_ind_q), 16'(par_res_q)};
        mpb_pkg::OFS_EST_KE: prdata <= {16'(par_f_q), 16'(par_ke_q)};
        mpb_pkg::OFS_SHD_RL: prdata <= {
          16'(pick((W)'(nvm_rl_q[31:16]), par_ind_q, ctrl_q[mpb_pkg::CTRL_SHADOW])),
          16'(pick((W)'(nvm_rl_q[15:0]), par_res_q, ctrl_q[mpb_pkg::CTRL_SHADOW]))};
        mpb_pkg::OFS_SHD_CL: prdata <= {
          16'(pick((W)'(nvm_cl_q[31:16]), cur_ki, ctrl_q[mpb_pkg::CTRL_SHADOW])),
          16'(pick((W)'(nvm_cl_q[15:0]), cur_kp, ctrl_q[mpb_pkg::CTRL_SHADOW]))};
        mpb_pkg::OFS_SHD_SL: prdata <= {
          16'(pick((W)'(nvm_sl_q[31:16]), spd_ki, ctrl_q[mpb_pkg::CTRL_SHADOW])),
          16'(pick((W)'(nvm_sl_q[15:0]), spd_kp, ctrl_q[mpb_pkg::CTRL_SHADOW]))};
        mpb_pkg::OFS_IDREF: prdata <= {fault_q, done_q, 14'h0, 16'(id_ref_q)};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // extraction sequencer
  // ----------------------------------------------------------------
  assign mech_run = ctrl_q[mpb_pkg::CTRL_MECH_EN] || nvm_sl_q == '0;
  assign ol_needed = ctrl_q[mpb_pkg::CTRL_KE_EN] || mech_run;
  // gains taken directly from the estimates; real loops retune from these seeds
  assign cur_kp = par_ind_q;
  assign cur_ki = par_res_q;
  assign spd_kp = par_j_q;
  assign spd_ki = par_f_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      cnt_q <= (cnt_q == 5'(mpb_pkg::STEP_CYCLES - 1)) ? '0 : cnt_q + 5'h01;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (ctrl_q[mpb_pkg::CTRL_START]) st_q <= ol_needed ? ST_ALIGN : ST_COAST;
        end
        ST_ALIGN: if (cnt_q == 5'(mpb_pkg::STEP_CYCLES - 1)) st_q <= ST_OPEN;
        ST_OPEN: if (cnt_q == 5'(mpb_pkg::STEP_CYCLES - 1))
          st_q <= mech_run ? ST_RAMP : ST_COAST;
        ST_RAMP: if (cnt_q == 5'(mpb_pkg::STEP_CYCLES - 1)) st_q <= ST_COAST;
        ST_COAST: if (cnt_q == 5'(mpb_pkg::STEP_CYCLES - 1)) st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // capture resistance and inductance during alignment, the other estimates during coasting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_res_q <= '0;
      par_ind_q <= '0;
      par_ke_q <= '0;
      par_j_q <= '0;
      par_f_q <= '0;
      fault_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (st_q == ST_ALIGN) begin
        par_res_q <= est_res;
        par_ind_q <= est_ind;
        fault_q <= 1'b0;
        done_q <= 1'b0;
      end
      if (st_q == ST_COAST) begin
        par_ke_q <= est_ke;
        par_j_q <= est_inertia;
        par_f_q <= est_friction;
        // after open loop or ramp the first coast cycle still has the bridge driving, so its reading is not bemf
        if (bridge_hiz_q && bemf_meas < limits_q[31:16]) fault_q <= 1'b1;
      end
      if (st_q == ST_DONE) done_q <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_hiz_q <= 1'b1;
      ol_slew_q <= '0;
      ol_cur_ref_q <= '0;
      ol_spd_ref_q <= '0;
    end else begin
      bridge_hiz_q <= st_q == ST_IDLE || st_q == ST_COAST || st_q == ST_DONE;
      if (ctrl_q[mpb_pkg::CTRL_OL_SEL]) begin
        ol_slew_q <= olcfg_q[W-1:0];
        ol_cur_ref_q <= (W)'(olcfg_q[31:16]);
        ol_spd_ref_q <= (W)'(speed_q[31:16]);
      end else begin
        ol_slew_q <= (W)'(olcfg_q[15:8]) + (W)'(olcfg_q[7:0]);
        ol_cur_ref_q <= pct((W)'(limits_q[15:0]), mpb_pkg::CUR_PCT);
        ol_spd_ref_q <= pct((W)'(brake_q[31:16]), mpb_pkg::SPD_PCT);
      end
      if (st_q == ST_RAMP) ol_cur_ref_q <= ol_cur_ref_q >> 1;
    end
  end

  // ----------------------------------------------------------------
  // deceleration choice
  // ----------------------------------------------------------------
  assign tgt = (W)'(speed_q[15:0]);
  assign delta_cmd = (speed_now > tgt) ? speed_now - tgt : '0;
  assign gap = delta_cmd;
  // forward mode checks deltas and modulation
  assign fwd_ok = mod_index < (W)'(delta_q[31:24]) << (W - 8) && delta_q[31:24] != 8'h00;
  assign want_brake = ctrl_q[mpb_pkg::CTRL_AB_EN] && !ctrl_q[mpb_pkg::CTRL_TORQUE];
  // surge follows the same decision, so brake and surge never overlap for a cycle
  always_comb begin
    brake_d = 1'b0;
    if (!want_brake) begin
      brake_d = 1'b0;
    end else if (ctrl_q[mpb_pkg::CTRL_REVERSE] || ctrl_q[mpb_pkg::CTRL_SPINDOWN]) begin
      brake_d = delta_cmd != '0;
    end else if (!brake_active_q) begin
      brake_d = fwd_ok && delta_cmd > (W)'(delta_q[7:0]);
    end else begin
      brake_d = fwd_ok && gap >= (W)'(delta_q[15:8]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_active_q <= 1'b0;
    end else begin
      brake_active_q <= brake_d;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      surge_active_q <= 1'b0;
      decel_rate_q <= '0;
    end else begin
      // surge control only while a speed reduction is still pending
      surge_active_q <= ctrl_q[mpb_pkg::CTRL_ANTI_SURGE_ENABLE] && !brake_d && delta_cmd != '0;
      decel_rate_q <= ctrl_q[mpb_pkg::CTRL_ANTI_SURGE_ENABLE] ? '0 : (W)'(nvm_ke_q[31:16]);
    end
  end
  mpb_brake_pi #(.W(W)) u_pi (
    .pclk(pclk), .presetn(presetn), .run(brake_active_q),
    .limit((W)'(brake_q[15:0])), .slew((W)'(nvm_ke_q[15:0])), .bus_cur(bus_cur),
    .kp(delta_q[23:16]), .ki(limits_q[23:16]), .ramp_q(pi_ramp), .id_ref_q(pi_id)
  );
  assign pi_ramp_unused = ^pi_ramp;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) id_ref_q <= '0;
    else id_ref_q <= pi_id;
  end

  a_ramp_skipped: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_OPEN && !mech_run) |=> st_q != ST_RAMP)
    else $error("ramp not skipped");
  a_hiz_coast: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_COAST |=> bridge_hiz_q)
    else $error("bridge not off in coast");
  a_no_brake_torque: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[mpb_pkg::CTRL_TORQUE] |=> !brake_active_q)
    else $error("brake in torque mode");
  a_brake_enable: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[mpb_pkg::CTRL_AB_EN] |=> !brake_active_q)
    else $error("brake while disabled");
  a_zero_modlim: assert property (@(posedge pclk) disable iff (!presetn)
    (delta_q[31:24] == 8'h00 && !ctrl_q[mpb_pkg::CTRL_REVERSE] &&
      !ctrl_q[mpb_pkg::CTRL_SPINDOWN]) |=> !brake_active_q)
    else $error("forward brake with zero limit");
  a_surge_mux: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[mpb_pkg::CTRL_ANTI_SURGE_ENABLE] |=> !surge_active_q)
    else $error("surge active while disabled");
  a_fault_low: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_COAST && bridge_hiz_q && bemf_meas < limits_q[31:16]) |=> fault_q)
    else $error("bemf fault missed");
  a_ol_select: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[mpb_pkg::CTRL_OL_SEL] && $stable(ctrl_q) && $stable(olcfg_q) && st_q != ST_RAMP)
      |=> ol_slew_q == $past(olcfg_q[W-1:0]))
    else $error("open loop slew not from extraction set");
endmodule // mpb_top

/* File: bench/mpb_motor_model.sv */
// motor and bridge stand-in for the extraction and braking block
// assumes the bench loads a start speed and the bemf level seen while coasting
`timescale 1ns/10ps
module mpb_motor_model #(
  parameter logic [15:0] EST_RES = 16'h0011,
  parameter logic [15:0] EST_IND = 16'h0022,
  parameter logic [15:0] EST_KE = 16'h0033,
  parameter logic [15:0] EST_INERTIA = 16'h0044,
  parameter logic [15:0] EST_FRICTION = 16'h0055
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench controls
  input wire logic load,
  input wire logic [15:0] spd_init,
  input wire logic [15:0] bemf_lvl,
  // from the block
  input wire logic bridge_hiz_q,
  input wire logic brake_active_q,
  input wire logic surge_active_q,
  // to the block
  output logic [15:0] speed_now,
  output logic [15:0] bus_cur,
  output logic [15:0] mod_index,
  output logic [15:0] bemf_meas,
  output logic [15:0] est_res,
  output logic [15:0] est_ind,
  output logic [15:0] est_ke,
  output logic [15:0] est_inertia,
  output logic [15:0] est_friction
);
  logic [15:0] spd_q;

  // --------------------------------------------------------------
  // rotor speed
  // --------------------------------------------------------------
  // speed only falls while the block decelerates, one step a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_q <= 16'h0000;
    end else if (load) begin
      spd_q <= spd_init;
    end else if ((brake_active_q || surge_active_q) && spd_q != 16'h0000) begin
      spd_q <= spd_q - 16'h0001;
    end
  end

  assign speed_now = spd_q;
  // modulation grows with speed, so the limit can cut in mid-deceleration
  assign mod_index = {spd_q[7:0], 8'h00};
  assign bus_cur = brake_active_q ? 16'h0010 : 16'h0000;
  // driven windings hide the bemf, so it reads inverted while the bridge drives
  assign bemf_meas = bridge_hiz_q ? bemf_lvl : ~bemf_lvl;
  assign est_res = EST_RES;
  assign est_ind = EST_IND;
  assign est_ke = EST_KE;
  assign est_inertia = EST_INERTIA;
  assign est_friction = EST_FRICTION;
endmodule // mpb_motor_model

/* File: bench/test_motor_param_extract_and_braking.sv */
// self-checking bench for the extraction sequencer and brake selection
// assumes mpb_top on a 100 MHz pclk with the motor model on its far side
`timescale 1ns/10ps
module test_motor_param_extract_and_braking;
  localparam logic [31:0] ST = 32'h1 << mpb_pkg::CTRL_START;
  localparam logic [31:0] KE = 32'h1 << mpb_pkg::CTRL_KE_EN;
  localparam logic [31:0] OS = 32'h1 << mpb_pkg::CTRL_OL_SEL;
  localparam logic [31:0] SH = 32'h1 << mpb_pkg::CTRL_SHADOW;
  localparam logic [31:0] AV = 32'h1 << mpb_pkg::CTRL_ANTI_SURGE_ENABLE;
  localparam logic [31:0] AB = 32'h1 << mpb_pkg::CTRL_AB_EN;
  localparam logic [31:0] TQ = 32'h1 << mpb_pkg::CTRL_TORQUE;
  localparam logic [31:0] RV = 32'h1 << mpb_pkg::CTRL_REVERSE;
  localparam logic [31:0] SD = 32'h1 << mpb_pkg::CTRL_SPINDOWN;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, load;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] speed_now, bus_cur, mod_index, bemf_meas, spd_init, bemf_lvl, gap;
  logic [15:0] est_res, est_ind, est_ke, est_inertia, est_friction;
  logic [15:0] ol_slew_q, ol_cur_ref_q, ol_spd_ref_q, id_ref_q, decel_rate_q;
  logic bridge_hiz_q, brake_active_q, surge_active_q, brk_seen, srg_seen, first, id_seen;
  logic [47:0] ol;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lows;

  mpb_top #(.W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .speed_now(speed_now), .bus_cur(bus_cur), .mod_index(mod_index),
    .bemf_meas(bemf_meas), .est_res(est_res), .est_ind(est_ind), .est_ke(est_ke),
    .est_inertia(est_inertia), .est_friction(est_friction), .bridge_hiz_q(bridge_hiz_q),
    .ol_slew_q(ol_slew_q), .ol_cur_ref_q(ol_cur_ref_q), .ol_spd_ref_q(ol_spd_ref_q),
    .id_ref_q(id_ref_q), .decel_rate_q(decel_rate_q), .brake_active_q(brake_active_q),
    .surge_active_q(surge_active_q));

  mpb_motor_model u_motor (.pclk(pclk), .presetn(presetn), .load(load), .spd_init(spd_init),
    .bemf_lvl(bemf_lvl), .bridge_hiz_q(bridge_hiz_q), .brake_active_q(brake_active_q),
    .surge_active_q(surge_active_q), .speed_now(speed_now), .bus_cur(bus_cur),
    .mod_index(mod_index), .bemf_meas(bemf_meas), .est_res(est_res), .est_ind(est_ind),
    .est_ke(est_ke), .est_inertia(est_inertia), .est_friction(est_friction));

  // --------------------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // entered just after an edge; ends one idle edge later so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends when pready is seen high; the bench timeout catches a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // one extraction pass; counts driven cycles and samples open-loop refs mid-spin
  task automatic run(input logic [31:0] c, input logic [15:0] bl);
    int i;
    bemf_lvl <= bl;
    wr(mpb_pkg::OFS_CTRL, c | ST);
    lows = 0;
    for (i = 1; i < 120; i++) begin
      @(posedge pclk);
      if (bridge_hiz_q === 1'b0) lows++;
      if (i == 20) ol = {ol_slew_q, ol_cur_ref_q, ol_spd_ref_q};
    end
    apb(1'b0, mpb_pkg::OFS_IDREF, 32'h0);
    $display("test extraction done");
  endtask

  task automatic brk(input logic [31:0] c, input logic [7:0] ml, input logic [15:0] s0,
                     input logic [15:0] tg, input logic eb, input logic ef, input string nm);
    int i;
    wr(mpb_pkg::OFS_CTRL, 32'h0);
    wr(mpb_pkg::OFS_SPEED, {16'h0222, s0});
    load <= 1'b1;
    spd_init <= s0;
    @(posedge pclk);
    load <= 1'b0;
    wr(mpb_pkg::OFS_DELTA, {ml, 8'h10, 8'h10, 8'h20});
    wr(mpb_pkg::OFS_CTRL, c);
    wr(mpb_pkg::OFS_SPEED, {16'h0222, tg});
    {brk_seen, srg_seen, first, id_seen} = 4'h0;
    for (i = 0; i < 300; i++) begin
      @(posedge pclk);
      if (!brk_seen && !srg_seen && (brake_active_q || surge_active_q)) first = brake_active_q;
      if (brake_active_q === 1'b1) begin
        brk_seen = 1'b1;
        gap = speed_now - tg;
        if (id_ref_q !== 16'h0000) id_seen = 1'b1;
      end
      if (surge_active_q === 1'b1) srg_seen = 1'b1;
    end
    chk({nm, " brake"}, {31'h0, eb}, {31'h0, brk_seen});
    chk({nm, " brake first"}, {31'h0, ef}, {31'h0, first});
    $display("test %s done", nm);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, load} = 5'h0;
    {paddr, pwdata, spd_init, bemf_lvl} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("hiz after reset", 32'h1, {31'h0, bridge_hiz_q});
    apb(1'b0, mpb_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", mpb_pkg::RESET_WORD, rd);
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
    wr(mpb_pkg::OFS_OLCFG, 32'h0300_0011);
    wr(mpb_pkg::OFS_LIMITS, 32'h0040_0190);
    wr(mpb_pkg::OFS_BRAKE, 32'h0100_0080);
    wr(mpb_pkg::OFS_SPEED, 32'h0222_0000);
    wr(mpb_pkg::OFS_NVM_RL, 32'h0005_0007);
    wr(mpb_pkg::OFS_NVM_KE, 32'h0033_0008);
    wr(mpb_pkg::OFS_NVM_CL, 32'h0002_0003);
    wr(mpb_pkg::OFS_NVM_SL, 32'h0004_0006);
    run(KE | OS, 16'h0080);
    chk("ext open loop refs", 32'h0011_0300, ol[47:16]);
    chk("ext speed ref", 32'h0222, {16'h0, ol[15:0]});
    chk("driven cycles no mech", 32'd32, lows);
    chk("fault and done", 32'h1, {30'h0, rd[31:30]});
    chk("coast at end", 32'h1, {31'h0, bridge_hiz_q});
    apb(1'b0, mpb_pkg::OFS_EST_RL, 32'h0);
    chk("est res ind", 32'h0022_0011, rd);
    apb(1'b0, mpb_pkg::OFS_EST_KE, 32'h0);
    chk("est ke friction", 32'h0055_0033, rd);
    apb(1'b0, mpb_pkg::OFS_SHD_RL, 32'h0);
    chk("shadow keeps stored", 32'h0005_0007, rd);
    wr(mpb_pkg::OFS_NVM_SL, 32'h0);
    run(KE, 16'h0010);
    chk("normal open loop refs", 32'h0140_0080, ol[31:0]);
    chk("driven cycles mech", 32'd48, lows);
    chk("bemf fault", 32'h3, {30'h0, rd[31:30]});
    wr(mpb_pkg::OFS_NVM_SL, 32'h0004_0006);
    run(32'h0, 16'h0080);
    chk("no open loop", 32'd0, lows);
    wr(mpb_pkg::OFS_CTRL, SH);
    apb(1'b0, mpb_pkg::OFS_SHD_RL, 32'h0);
    chk("shadow takes est", 32'h0022_0011, rd);
    wr(mpb_pkg::OFS_CTRL, 32'h0);
    wr(mpb_pkg::OFS_NVM_RL, 32'h0);
    apb(1'b0, mpb_pkg::OFS_SHD_RL, 32'h0);
    chk("zero stored uses est", 32'h0022_0011, rd);
    // limit at full scale first, as tuning starts there
    brk(AV | AB, 8'hff, 16'h00c0, 16'h0040, 1'b1, 1'b1, "wide");
    chk("exit gap", 32'h1, {31'h0, gap >= 16'h000d && gap <= 16'h0012});
    chk("surge after exit", 32'h1, {31'h0, srg_seen});
    chk("id ref driven", 32'h1, {31'h0, id_seen});
    brk(AV | AB, 8'hff, 16'h0060, 16'h0050, 1'b0, 1'b0, "narrow");
    chk("narrow surge", 32'h1, {31'h0, srg_seen});
    brk(AV, 8'hff, 16'h00c0, 16'h0040, 1'b0, 1'b0, "brake off");
    brk(AV | AB, 8'h00, 16'h00c0, 16'h0040, 1'b0, 1'b0, "zero limit");
    brk(AV | AB | RV, 8'h00, 16'h0060, 16'h0050, 1'b1, 1'b1, "reverse");
    brk(AV | AB | SD, 8'h00, 16'h00c0, 16'h0040, 1'b1, 1'b1, "spindown");
    brk(AV | AB | TQ, 8'hff, 16'h00c0, 16'h0040, 1'b0, 1'b0, "torque");
    brk(AV | AB, 8'h80, 16'h00c0, 16'h0040, 1'b1, 1'b0, "mod limit");
    brk(32'h0, 8'hff, 16'h00c0, 16'h0040, 1'b0, 1'b0, "closed loop");
    chk("no surge when off", 32'h0, {31'h0, srg_seen});
    chk("closed loop rate", 32'h0033, {16'h0, decel_rate_q});
    final_report();
  end
endmodule // test_motor_param_extract_and_braking
